// ---- verilog/sop_pkg.sv ----
package sop_pkg;
	localparam int unsigned  CLK_FREQ_MHZ = 100;
	localparam int unsigned  CLK_NS       = 1000 / CLK_FREQ_MHZ;
	localparam logic [31:0]  STEP_NS      = 32'(CLK_NS);
	localparam int unsigned  IN_CH        = 4;

	localparam logic [7:0]   A_PCNT   = 8'h00;
	localparam logic [7:0]   A_MODE   = 8'h04;
	localparam logic [7:0]   A_CYCLE  = 8'h08;
	localparam logic [7:0]   A_SHIFT  = 8'h0C;
	localparam logic [7:0]   A_SUPP   = 8'h10;
	localparam logic [7:0]   A_MINCYC = 8'h14;
	localparam logic [7:0]   A_GAP    = 8'h18;
	localparam logic [7:0]   A_CMD    = 8'h1C;
	localparam logic [7:0]   A_DLY    = 8'h20;
	localparam logic [7:0]   A_MISS   = 8'h24;
	localparam logic [7:0]   A_OVER   = 8'h28;
	localparam logic [7:0]   A_SHORT  = 8'h2C;
	localparam logic [7:0]   A_LATE   = 8'h30;
	localparam logic [7:0]   A_ISTS   = 8'h34;
	localparam logic [7:0]   A_IMASK  = 8'h38;
	localparam logic [7:0]   A_ACNT   = 8'h3C;
	localparam logic [7:0]   A_ASG0   = 8'h40;

	localparam logic [7:0]   PCNT_VAL  = 8'h20;
	localparam logic [15:0]  SUPP_VAL  = 16'h8007;
	localparam logic [7:0]   ACNT_RST  = 8'h04;
	localparam logic [15:0]  ASG_BASE  = 16'h1A00;
	localparam logic [15:0]  CNT_MAX   = 16'hFFFF;
	localparam int unsigned  MEAS_BIT  = 0;

	localparam logic [15:0]  M_FREE = 16'h0000;
	localparam logic [15:0]  M_SM   = 16'h0001;
	localparam logic [15:0]  M_DC0  = 16'h0002;
	localparam logic [15:0]  M_DC1  = 16'h0003;

	// Interrupt status bit positions
	localparam int unsigned  EV_MISS  = 0;
	localparam int unsigned  EV_OVER  = 1;
	localparam int unsigned  EV_SHORT = 2;
	localparam int unsigned  EV_LATE  = 3;

	localparam logic [1:0]   RESP_OK  = 2'h0;
	localparam logic [1:0]   RESP_ERR = 2'h2;
endpackage

// ---- verilog/sop_top.sv ----
// Functional notes
// RL1: Mode codes: 0 free, 1 SM, 2 SYNC0, 3 SYNC1
// RL2: Cycle time in ns, meaning per mode
// RL3: DC SYNC0 mode drives outputs after shift
// RL4: Supported-modes bitmap reads 0x8007, read-only
// RL5: Command 1 starts, 0 stops measurement
// RL6: Measurement keeps maxima, cleared at start
// RL7: Missed SM events counted in DC, OP
// RL8: Overrun counted in OP, late or early
// RL9: SYNC0 to SYNC1 gap too short counted
// RL10: Late flag shows outputs driven late
// RL11: Minimum SYNC0-SYNC1 gap reported read-only
// RL12: SYNC1 to output delay reported read-only
// RL13: Input assign entries default 0x1A0n
// RL14: Minimum cycle time read-only, reset zero
// RL15: Parameter count reads 0x20
// RL16: Errors clear on reset, OP entry; saturate (a short gap in the entry cycle bumps the old shortc instead)
module sop_top (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	input  wire logic        sm_event_i,
	input  wire logic        sync0_i,
	input  wire logic        sync1_i,
	input  wire logic        calc_done_i,
	input  wire logic        op_state_i,
	output logic             outputs_drive_o,
	output logic             irq_o
);
	typedef struct packed {
		logic                    awready;
		logic                    wready;
		logic                    bvalid;
		logic [1:0]              bresp;
		logic                    arready;
		logic                    rvalid;
		logic [1:0]              rresp;
		logic [31:0]             rdata;
		logic [7:0]              raddr;
		logic                    rpend;
		logic                    aw_got;
		logic                    w_got;
		logic [7:0]              awaddr;
		logic [31:0]             wdata;
		logic [3:0]              wstrb;
		logic [15:0]             mode;
		logic [31:0]             cycle;
		logic [31:0]             shift;
		logic [31:0]             mincyc;
		logic [31:0]             gap;
		logic [15:0]             cmd;
		logic [31:0]             dly;
		logic [15:0]             miss;
		logic [15:0]             over;
		logic [15:0]             shortc;
		logic                    late;
		logic [3:0]              ists;
		logic [3:0]              imask;
		logic [7:0]              acnt;
		logic [3:0][15:0]        asg;
		logic [31:0]             local_ns;
		logic                    busy;
		logic [31:0]             proc_ns;
		logic [31:0]             since_s0;
		logic                    sm_seen;
		logic                    run;
		logic [31:0]             run_ns;
		logic [31:0]             target;
		logic                    op;
		logic                    drive;
		logic                    irq;
	} sop_state_t;

	sop_state_t  q;
	sop_state_t  n;
	logic [31:0] rd;
	logic        rd_err;
	logic [31:0] wr;
	logic        wr_err;
	logic [31:0] meas_ns;
	logic        dc;
	logic        start;
	logic [3:0]  ev;

	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] val,
		input logic [3:0]  strb
	);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				res[8*i +: 8] = val[8*i +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic [15:0] bump(input logic [15:0] c);
		// Saturate so a long fault storm never reads as zero
		return (c == sop_pkg::CNT_MAX) ? c : c + 16'h0001; // RL16
	endfunction

	function automatic logic [31:0] max32(
		input logic [31:0] a,
		input logic [31:0] b
	);
		return (a > b) ? a : b;
	endfunction

	always_comb
	begin
		n = q;
		rd = 32'h0000_0000;
		rd_err = 1'b0;
		wr = 32'h0000_0000;
		wr_err = 1'b0;
		ev = 4'h0;
		n.drive = 1'b0;
		dc = (q.mode == sop_pkg::M_DC0) || (q.mode == sop_pkg::M_DC1);
		meas_ns = q.proc_ns + sop_pkg::STEP_NS;

		// Cycle start source per mode
		start = 1'b0;
		if (q.mode == sop_pkg::M_FREE)
		begin
			n.local_ns = q.local_ns + sop_pkg::STEP_NS;
			if (q.cycle != 32'h0000_0000 &&
				q.local_ns + sop_pkg::STEP_NS >= q.cycle) // RL2
			begin
				n.local_ns = 32'h0000_0000;
				start = 1'b1;
			end
		end
		else if (q.mode == sop_pkg::M_SM)
		begin
			start = sm_event_i; // RL1
		end
		else if (dc)
		begin
			start = sync0_i; // RL1
		end

		// Free run and SM mode drive on the cycle start itself
		if (!dc && start)
		begin
			n.drive = 1'b1;
		end

		// Overrun: new cycle while the previous one still computes
		if (start && q.busy && op_state_i && q.op)
		begin
			ev[sop_pkg::EV_OVER] = 1'b1; // RL8
		end
		if (q.busy)
		begin
			n.proc_ns = meas_ns;
		end
		if (calc_done_i && q.busy)
		begin
			n.busy = 1'b0;
			if (q.cmd[sop_pkg::MEAS_BIT])
			begin
				n.mincyc = max32(q.mincyc, meas_ns); // RL6
				n.gap = max32(q.gap, meas_ns); // RL6
				n.dly = max32(q.dly, meas_ns); // RL6
				n.shift = max32(q.shift, meas_ns); // RL6
			end
		end
		if (start)
		begin
			n.busy = 1'b1;
			n.proc_ns = 32'h0000_0000;
		end

		// Output shift timer, armed by SYNC0 or SYNC1
		if (q.run)
		begin
			n.run_ns = q.run_ns + sop_pkg::STEP_NS;
			if (q.run_ns >= q.target)
			begin
				n.run = 1'b0;
				n.drive = 1'b1;
			end
		end
		n.since_s0 = q.since_s0 + sop_pkg::STEP_NS;
		if (sm_event_i)
		begin
			n.sm_seen = 1'b1;
		end
		if (dc && sync0_i)
		begin
			n.late = q.run; // RL10
			if (q.run)
			begin
				ev[sop_pkg::EV_LATE] = 1'b1; // RL10
			end
			if (!q.sm_seen && op_state_i && q.op)
			begin
				ev[sop_pkg::EV_MISS] = 1'b1; // RL7
			end
			n.sm_seen = sm_event_i;
			n.since_s0 = 32'h0000_0000;
			if (q.mode == sop_pkg::M_DC0)
			begin
				n.run = 1'b1; // RL3
				n.run_ns = 32'h0000_0000;
				n.target = q.shift; // RL3
			end
		end
		if (dc && sync1_i)
		begin
			if (q.since_s0 < q.gap)
			begin
				ev[sop_pkg::EV_SHORT] = 1'b1; // RL9
			end
			if (q.mode == sop_pkg::M_DC1)
			begin
				n.run = 1'b1;
				n.run_ns = 32'h0000_0000;
				n.target = q.dly; // RL12
			end
		end
		if (!dc)
		begin
			n.late = 1'b0; // RL10
			n.run = 1'b0;
		end

		// Error counters restart on each entry to OP; a short gap in that cycle bumps the old shortc instead
		n.op = op_state_i;
		if (op_state_i && !q.op)
		begin
			n.miss = 16'h0000; // RL16
			n.over = 16'h0000; // RL16
			n.shortc = 16'h0000; // RL16
			n.late = 1'b0; // RL16
		end
		if (ev[sop_pkg::EV_MISS])
		begin
			n.miss = bump(q.miss); // RL7
		end
		if (ev[sop_pkg::EV_OVER])
		begin
			n.over = bump(q.over); // RL8
		end
		if (ev[sop_pkg::EV_SHORT])
		begin
			n.shortc = bump(q.shortc); // RL9
		end

		// Read decode
		if (q.raddr == sop_pkg::A_PCNT)
			rd = {24'h00_0000, sop_pkg::PCNT_VAL}; // RL15
		else if (q.raddr == sop_pkg::A_MODE)
			rd = {16'h0000, q.mode};
		else if (q.raddr == sop_pkg::A_CYCLE)
			rd = q.cycle;
		else if (q.raddr == sop_pkg::A_SHIFT)
			rd = q.shift;
		else if (q.raddr == sop_pkg::A_SUPP)
			rd = {16'h0000, sop_pkg::SUPP_VAL}; // RL4
		else if (q.raddr == sop_pkg::A_MINCYC)
			rd = q.mincyc; // RL14
		else if (q.raddr == sop_pkg::A_GAP)
			rd = q.gap; // RL11
		else if (q.raddr == sop_pkg::A_CMD)
			rd = {16'h0000, q.cmd};
		else if (q.raddr == sop_pkg::A_DLY)
			rd = q.dly; // RL12
		else if (q.raddr == sop_pkg::A_MISS)
			rd = {16'h0000, q.miss};
		else if (q.raddr == sop_pkg::A_OVER)
			rd = {16'h0000, q.over};
		else if (q.raddr == sop_pkg::A_SHORT)
			rd = {16'h0000, q.shortc};
		else if (q.raddr == sop_pkg::A_LATE)
			rd = {31'h0000_0000, q.late};
		else if (q.raddr == sop_pkg::A_ISTS)
			rd = {28'h000_0000, q.ists};
		else if (q.raddr == sop_pkg::A_IMASK)
			rd = {28'h000_0000, q.imask};
		else if (q.raddr == sop_pkg::A_ACNT)
			rd = {24'h00_0000, q.acnt};
		else if (q.raddr[7:4] == sop_pkg::A_ASG0[7:4] &&
			q.raddr[1:0] == 2'h0)
			rd = {16'h0000, q.asg[q.raddr[3:2]]}; // RL13
		else
			rd_err = 1'b1;

		// Read channel: address in one cycle, data the next
		if (q.rvalid && s_axi_rready_i)
		begin
			n.rvalid = 1'b0;
		end
		if (q.arready && s_axi_arvalid_i)
		begin
			n.raddr = s_axi_araddr_i;
			n.rpend = 1'b1;
		end
		// Explicit pending bit: idle after reset must not fetch a reply
		if (q.rpend)
		begin
			n.rpend = 1'b0;
			n.rvalid = 1'b1;
			n.rdata = rd;
			n.rresp = rd_err ? sop_pkg::RESP_ERR : sop_pkg::RESP_OK;
		end
		n.ists = q.ists;
		if (q.rpend && q.raddr == sop_pkg::A_ISTS)
		begin
			n.ists = 4'h0;
		end
		// Set wins over the read clear
		n.ists = n.ists | ev;
		n.arready = !n.rvalid && !n.rpend;

		// Write channel
		if (q.bvalid && s_axi_bready_i)
		begin
			n.bvalid = 1'b0;
		end
		if (q.awready && s_axi_awvalid_i)
		begin
			n.aw_got = 1'b1;
			n.awaddr = s_axi_awaddr_i;
		end
		if (q.wready && s_axi_wvalid_i)
		begin
			n.w_got = 1'b1;
			n.wdata = s_axi_wdata_i;
			n.wstrb = s_axi_wstrb_i;
		end
		if (q.aw_got && q.w_got && !q.bvalid)
		begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			if (q.awaddr == sop_pkg::A_MODE)
			begin
				wr = merge({16'h0000, q.mode}, q.wdata, q.wstrb);
				n.mode = wr[15:0]; // RL1
			end
			else if (q.awaddr == sop_pkg::A_CYCLE)
				n.cycle = merge(q.cycle, q.wdata, q.wstrb); // RL2
			else if (q.awaddr == sop_pkg::A_SHIFT)
				n.shift = merge(q.shift, q.wdata, q.wstrb); // RL3
			else if (q.awaddr == sop_pkg::A_CMD)
			begin
				wr = merge({16'h0000, q.cmd}, q.wdata, q.wstrb);
				n.cmd = wr[15:0]; // RL5
				if (wr[sop_pkg::MEAS_BIT] && !q.cmd[sop_pkg::MEAS_BIT])
				begin
					n.mincyc = 32'h0000_0000; // RL6
					n.gap = 32'h0000_0000; // RL6
					n.dly = 32'h0000_0000; // RL6
					n.shift = 32'h0000_0000; // RL6
				end
			end
			else if (q.awaddr == sop_pkg::A_IMASK)
			begin
				wr = merge({28'h000_0000, q.imask}, q.wdata, q.wstrb);
				n.imask = wr[3:0];
			end
			else if (q.awaddr == sop_pkg::A_ACNT)
			begin
				wr = merge({24'h00_0000, q.acnt}, q.wdata, q.wstrb);
				n.acnt = wr[7:0];
			end
			else if (q.awaddr[7:4] == sop_pkg::A_ASG0[7:4] &&
				q.awaddr[1:0] == 2'h0)
			begin
				wr = merge({16'h0000, q.asg[q.awaddr[3:2]]},
					q.wdata, q.wstrb);
				n.asg[q.awaddr[3:2]] = wr[15:0]; // RL13
			end
			else if (q.awaddr == sop_pkg::A_PCNT ||
				q.awaddr == sop_pkg::A_SUPP ||
				(q.awaddr >= sop_pkg::A_MINCYC &&
				q.awaddr <= sop_pkg::A_ISTS))
				wr_err = 1'b0; // Read-only: write ignored
			else
				wr_err = 1'b1;
			n.bresp = wr_err ? sop_pkg::RESP_ERR : sop_pkg::RESP_OK;
		end
		n.awready = !n.aw_got && !n.bvalid;
		n.wready = !n.w_got && !n.bvalid;
		n.irq = |(n.ists & n.imask);
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			q <= '0;
			q.mode <= sop_pkg::M_FREE;
			q.acnt <= sop_pkg::ACNT_RST;
			for (int i = 0; i < sop_pkg::IN_CH; i++)
			begin
				q.asg[i] <= sop_pkg::ASG_BASE + 16'(i); // RL13
			end
		end
		else
		begin
			q <= n;
		end
	end

	assign s_axi_awready_o = q.awready;
	assign s_axi_wready_o = q.wready;
	assign s_axi_bvalid_o = q.bvalid;
	assign s_axi_bresp_o = q.bresp;
	assign s_axi_arready_o = q.arready;
	assign s_axi_rvalid_o = q.rvalid;
	assign s_axi_rdata_o = q.rdata;
	assign s_axi_rresp_o = q.rresp;
	assign outputs_drive_o = q.drive;
	assign irq_o = q.irq;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	sm_drive_a: assert property ( // RL1
		(q.mode == sop_pkg::M_SM && sm_event_i) |-> ##1 outputs_drive_o)
		else $error("SM event did not drive outputs");
	free_wrap_a: assert property ( // RL2
		(q.mode == sop_pkg::M_FREE && q.cycle != 32'h0000_0000 &&
		q.local_ns + sop_pkg::STEP_NS >= q.cycle) |=> outputs_drive_o)
		else $error("Free run period did not drive outputs");
	shift_zero_a: assert property ( // RL3
		(q.mode == sop_pkg::M_DC0 && sync0_i && q.shift == 0 &&
		$stable(q.mode)) |-> ##2 outputs_drive_o)
		else $error("Zero shift did not drive two cycles later");
	bitmap_read_a: assert property ( // RL4
		(s_axi_rvalid_o && q.raddr == sop_pkg::A_SUPP) |->
		s_axi_rdata_o == 32'h0000_8007)
		else $error("Supported modes readback wrong");
	meas_clear_a: assert property ( // RL6
		$rose(q.cmd[0]) |-> q.mincyc == 0 && q.gap == 0 && q.dly == 0)
		else $error("Measured values not cleared at start");
	meas_max_a: assert property ( // RL6
		(q.cmd[0] && $past(q.cmd[0])) |-> q.mincyc >= $past(q.mincyc))
		else $error("Measured minimum cycle decreased");
	miss_count_a: assert property ( // RL7
		(dc && sync0_i && !q.sm_seen && op_state_i && q.op &&
		q.miss != 16'hFFFF) |=> q.miss == $past(q.miss) + 16'h0001)
		else $error("Missed event not counted");
	over_count_a: assert property ( // RL8
		(start && q.busy && op_state_i && q.op &&
		q.over != 16'hFFFF) |=> q.over == $past(q.over) + 16'h0001)
		else $error("Cycle overrun not counted");
	short_count_a: assert property ( // RL9
		(dc && sync1_i && q.since_s0 < q.gap && (q.op || !op_state_i) &&
		q.shortc != 16'hFFFF) |=> q.shortc == $past(q.shortc) + 16'h0001)
		else $error("Short gap not counted");
	late_clear_a: assert property ( // RL10
		!dc |=> !q.late)
		else $error("Late flag set outside DC mode");
	op_clear_a: assert property ( // RL16
		(op_state_i && !q.op) |=> q.over == 0 && q.miss == 0)
		else $error("Counters not cleared on OP entry");

	dc_drive_c: cover property (
		q.mode == sop_pkg::M_DC0 && sync0_i ##[1:50] outputs_drive_o);
	late_c: cover property ($rose(q.late));
	irq_c: cover property ($rose(irq_o));
endmodule

// ---- tb/sop_evt_model.sv ----
module sop_evt_model (
	input  wire logic       clk_i,
	input  wire logic [2:0] fire_i,
	input  wire logic [7:0] calc_lat_i,
	output logic            sm_event_o,
	output logic            sync0_o,
	output logic            sync1_o,
	output logic            calc_done_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt_q;
	initial
	begin
		cnt_q = 0;
		sm_event_o = 0;
		sync0_o = 0;
		sync1_o = 0;
		calc_done_o = 0;
	end
	// Zero latency: the cycle never finishes, to provoke overruns
	always @(posedge clk_i)
	begin
		sm_event_o <= fire_i[0];
		sync0_o <= fire_i[1];
		sync1_o <= fire_i[2];
		calc_done_o <= (cnt_q == 1);
		if (fire_i[1] && calc_lat_i != 0)
			cnt_q <= calc_lat_i;
		else if (cnt_q != 0)
			cnt_q <= cnt_q - 1;
	end
endmodule

// ---- tb/sop_top_tb_top.sv ----
module sop_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk;
	logic        rst;
	logic [7:0]  awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic [3:0]  strb;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [7:0]  araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic [2:0]  fire;
	logic [7:0]  lat;
	logic        op;
	logic        sm;
	logic        s0;
	logic        s1;
	logic        cd;
	logic        drv;
	logic        irq;
	int          n_fail;
	int          checked;
	int          cyc;
	int          seed;
	logic [31:0] mdl [0:19];

	sop_top sop_top_inst (.sys_clk_i(clk), .rst_i(rst),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(strb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .sm_event_i(sm), .sync0_i(s0),
		.sync1_i(s1), .calc_done_i(cd), .op_state_i(op),
		.outputs_drive_o(drv), .irq_o(irq));

	sop_evt_model sop_evt_model_inst (.clk_i(clk), .fire_i(fire),
		.calc_lat_i(lat), .sm_event_o(sm), .sync0_o(s0),
		.sync1_o(s1), .calc_done_o(cd));

	initial
	begin
		clk = 0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			n_fail++;
			tally_and_finish();
		end
	end

	// Writable bits per word, with the mask word 0x38 left at zero; the model keeps only those
	function automatic logic [31:0] rwm(input logic [7:0] a);
		case (a)
			8'h04, 8'h1C: rwm = 32'h0000_FFFF;
			8'h08, 8'h0C: rwm = 32'hFFFF_FFFF;
			8'h3C: rwm = 32'h0000_00FF;
			8'h40, 8'h44, 8'h48, 8'h4C: rwm = 32'h0000_FFFF;
			default: rwm = 32'h0000_0000;
		endcase
	endfunction

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic        aw_ok;
		logic        w_ok;
		logic [31:0] bm;
		aw_ok = 0;
		w_ok = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(aw_ok && w_ok))
		begin
			@(posedge clk);
			if (!aw_ok && awready === 1'b1)
			begin
				awvalid <= 0;
				aw_ok = 1;
			end
			if (!w_ok && wready === 1'b1)
			begin
				wvalid <= 0;
				w_ok = 1;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		bready <= 0;
		chk(32'(bresp), 32'(a < 8'h50 ? 2'h0 : 2'h2));
		bm = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		bm = bm & rwm(a);
		if (a < 8'h50)
			mdl[a[6:2]] = (mdl[a[6:2]] & ~bm) | (d & bm);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 0;
		do @(posedge clk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(d, e);
		chk(32'(r), 32'h0000_0000);
	endtask

	task automatic fire_ev(input logic [2:0] f);
		@(posedge clk);
		fire <= f;
		@(posedge clk);
		fire <= 0;
	endtask

	// Edges from the fire request until the design drives outputs
	task automatic drv_gap(input logic [2:0] f, output int n);
		@(posedge clk);
		fire <= f;
		n = 1;
		do
		begin
			@(posedge clk);
			fire <= 3'b000;
			n++;
		end
		while (drv !== 1'b1 && n < 200);
	endtask

	initial
	begin
		logic [31:0] d;
		logic [31:0] a;
		logic [31:0] b;
		logic [1:0]  r;
		int          n;
		n_fail = 0;
		checked = 0;
		cyc = 0;
		seed = 28;
		rst = 1;
		awaddr = 0;
		awvalid = 0;
		wdata = 0;
		wvalid = 0;
		bready = 0;
		araddr = 0;
		arvalid = 0;
		rready = 0;
		fire = 0;
		strb = 4'hF;
		lat = 0;
		op = 0;
		for (int i = 0; i < 20; i++)
			mdl[i] = (i >= 16) ? 32'h0000_1A00 + i - 16 : 32'h0000_0000;
		mdl[0] = 32'h0000_0020;
		mdl[4] = 32'h0000_8007;
		mdl[15] = 32'h0000_0004;
		repeat (5) @(posedge clk);
		rst <= 0;
		repeat (2) @(posedge clk);
		for (int i = 0; i < 20; i++)
			rdchk(8'(i * 4), mdl[i]);
		// Status and mask stay out: random bits would raise the irq
		for (int i = 0; i < 20; i++)
			if (i != 7 && i != 13 && i != 14)
				wr(8'(i * 4), $random(seed));
		for (int i = 0; i < 20; i++)
			rdchk(8'(i * 4), mdl[i]);
		wr(8'hFC, 32'h0000_1234);
		rd(8'hFC, d, r);
		chk(d, 32'h0000_0000);
		chk(32'(r), 32'h0000_0002);
		strb <= 4'h2;
		wr(8'h08, 32'hA5A5_A5A5);
		strb <= 4'hF;
		rdchk(8'h08, mdl[2]);
		for (int m = 0; m < 4; m++)
		begin
			wr(8'h04, 32'(m));
			rdchk(8'h04, 32'(m));
		end
		wr(8'h08, 32'h0000_0064);
		wr(8'h04, 32'h0000_0000);
		drv_gap(3'b000, n);
		drv_gap(3'b000, n);
		chk(32'(n), 32'h0000_000A);
		wr(8'h08, 32'h0000_0096);
		drv_gap(3'b000, n);
		drv_gap(3'b000, n);
		chk(32'(n), 32'h0000_000F);
		wr(8'h08, 32'h0000_0000);
		repeat (20) @(posedge clk);
		drv_gap(3'b000, n);
		chk(32'(n), 32'h0000_00C8);
		wr(8'h04, 32'h0000_0001);
		drv_gap(3'b001, n);
		chk(32'(n >= 3 && n <= 6), 32'h0000_0001);
		wr(8'h04, 32'h0000_0002);
		wr(8'h0C, 32'h0000_0000);
		drv_gap(3'b010, n);
		chk(32'(n >= 3 && n <= 7), 32'h0000_0001);
		wr(8'h0C, 32'h0000_0032);
		drv_gap(3'b010, n);
		chk(32'(n >= 8 && n <= 12), 32'h0000_0001);
		wr(8'h0C, 32'h0000_0000);
		op <= 1;
		lat <= 3;
		wr(8'h38, 32'h0000_0003);
		repeat (2)
		begin
			fire_ev(3'b011);
			repeat (20) @(posedge clk);
		end
		rd(8'h24, a, r);
		rd(8'h28, b, r);
		rd(8'h34, d, r);
		lat <= 0;
		repeat (2)
		begin
			fire_ev(3'b010);
			repeat (20) @(posedge clk);
		end
		rdchk(8'h24, a + 1);
		rdchk(8'h28, b + 1);
		chk(32'(irq), 32'h0000_0001);
		rdchk(8'h34, 32'h0000_0003);
		repeat (2) @(posedge clk);
		chk(32'(irq), 32'h0000_0000);
		wr(8'h0C, 32'h0000_01F4);
		fire_ev(3'b010);
		repeat (10) @(posedge clk);
		fire_ev(3'b010);
		repeat (5) @(posedge clk);
		rdchk(8'h30, 32'h0000_0001);
		wr(8'h04, 32'h0000_0000);
		rdchk(8'h30, 32'h0000_0000);
		op <= 0;
		repeat (3) @(posedge clk);
		op <= 1;
		repeat (3) @(posedge clk);
		for (int i = 9; i < 13; i++)
			rdchk(8'(i * 4), 32'h0000_0000);
		wr(8'h04, 32'h0000_0002);
		wr(8'h0C, 32'h0000_0000);
		lat <= 6;
		wr(8'h1C, 32'h0000_0001);
		fire_ev(3'b010);
		repeat (20) @(posedge clk);
		rd(8'h14, d, r);
		chk(32'(d != 0), 32'h0000_0001);
		rdchk(8'h18, d);
		rdchk(8'h20, d);
		rdchk(8'h0C, d);
		wr(8'h1C, 32'h0000_0000);
		rd(8'h2C, a, r);
		fire_ev(3'b010);
		fire_ev(3'b100);
		repeat (20) @(posedge clk);
		rdchk(8'h2C, a + 1);
		wr(8'h1C, 32'h0000_0001);
		rdchk(8'h14, 32'h0000_0000);
		rdchk(8'h18, 32'h0000_0000);
		tally_and_finish();
	end
endmodule
